/* rtl/ccp_pkg.sv */
// Shared constants and carrier types for the cluster register clear and preset controller.
package ccp_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int NUM_CELLS = 10;
   localparam int NUM_GLOBAL = 4;
   localparam int ADDR_W = 8;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_GLOBAL = 8'h04;
   localparam logic [7:0] ADDR_GPIO = 8'h08;
   localparam logic [7:0] ADDR_CELL_CFG = 8'h0c;
   localparam logic [7:0] ADDR_CELL_DATA = 8'h10;
   localparam logic [7:0] ADDR_POWERUP = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int CTRL_SCLR = 0;
   localparam int CTRL_SLOAD = 1;
   localparam int CTRL_ENA = 2;
   localparam int CTRL_ACLR1 = 3;
   localparam int CTRL_ALOAD = 4;
   localparam int CTRL_ALOAD_ONE = 5;
   localparam int CTRL_PWR_LOAD = 6;

   // ****************************************************************
   // Global register fields
   // ****************************************************************
   localparam int GLB_PIN_CLK = 0;
   localparam int GLB_INT_VAL = 4;
   localparam int GLB_INT_SEL = 8;
   localparam int GLB_COL_EN = 12;
   localparam int GLB_CLK0_SEL = 16;
   localparam int GLB_CLK1_SEL = 18;
   localparam int GLB_CLR_SEL = 20;

   // ****************************************************************
   // GPIO register fields
   // ****************************************************************
   localparam int GPIO_OUT = 0;
   localparam int GPIO_OE = 4;
   localparam int GPIO_CWC_OUT = 8;
   localparam int GPIO_CWC_OE = 9;

   // ****************************************************************
   // Cell configuration, data and status fields
   // ****************************************************************
   localparam int CFG_CLK_PICK = 0;
   localparam int CFG_CLR_PICK = 10;
   localparam int CFG_CHAIN_SEL = 20;
   localparam int DAT_DATA = 0;
   localparam int DAT_FOURTH = 10;
   localparam int DAT_CASCADE = 20;
   localparam int STS_Q = 0;
   localparam int STS_PINS = 10;
   localparam int STS_CWC_PIN = 14;
   localparam int STS_HOLD = 15;
   localparam int STS_COLUMN = 16;

   // ****************************************************************
   // Writable masks and reset values
   // ****************************************************************
   localparam logic [31:0] MASK_CTRL = 32'h0000_003f;
   localparam logic [31:0] MASK_GLOBAL = 32'h003f_ffff;
   localparam logic [31:0] MASK_GPIO = 32'h0000_03ff;
   localparam logic [31:0] MASK_CELL = 32'h3fff_ffff;
   localparam logic [31:0] MASK_POWERUP = 32'h0000_03ff;
   localparam logic [31:0] RST_CTRL = 32'h0000_0004;
   localparam logic [31:0] RST_GLOBAL = 32'h0000_f000;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic RST_CELL_Q = 1'b0;

   // Clear hold state machine, Gray coded.
   typedef enum logic [1:0] {
      CCP_HOLD = 2'b00,
      CCP_USER = 2'b01
   } ccp_state_t;

   // Per-cell register controls, gathered from the cluster-wide lines.
   typedef struct packed {
      logic chip_clr;
      logic aclr;
      logic aload;
      logic aload_one;
      logic pwr_load;
      logic pwr_val;
      logic clk_evt;
      logic ena;
      logic sclr;
      logic sload;
   } ccp_cell_ctrl_t;

endpackage

/* rtl/ccp_sync2.sv */
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module ccp_sync2 #(
   parameter int WIDTH = 1
)
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         meta <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

/* rtl/ccp_cell.sv */
// One cell register with chip clear, asynchronous clear and load, and clocked controls.
`timescale 1ns/1ps
module ccp_cell
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire ccp_pkg::ccp_cell_ctrl_t ctrl_in,
   input wire logic d_in,
   input wire logic load_data_in,
   output logic q_out
);
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         q_out <= ccp_pkg::RST_CELL_Q;
      end
      else if (ctrl_in.chip_clr)
      begin
         q_out <= 1'b0;
      end
      else if (ctrl_in.aclr)
      begin
         q_out <= 1'b0;
      end
      else if (ctrl_in.aload)
      begin
         q_out <= ctrl_in.aload_one ? 1'b1 : load_data_in;
      end
      else if (ctrl_in.pwr_load)
      begin
         q_out <= ctrl_in.pwr_val;
      end
      else if (ctrl_in.clk_evt && ctrl_in.ena)
      begin
         if (ctrl_in.sclr)
         begin
            q_out <= 1'b0;
         end
         else if (ctrl_in.sload)
         begin
            q_out <= load_data_in;
         end
         else
         begin
            q_out <= d_in;
         end
      end
   end
endmodule

/* rtl/ccp_cluster_ctrl.sv */
// Logic cluster register control with global network, chip-wide clear and APB registers.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module ccp_cluster_ctrl #(
   parameter logic CWC_ENABLE = 1'b1
)
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [3:0] global_clock_pins_in,
   output logic [3:0] global_clock_pins_out,
   output logic [3:0] global_clock_pins_oe_out,
   input wire logic chip_wide_clear_pin_n_in,
   output logic chip_wide_clear_pin_n_out,
   output logic chip_wide_clear_pin_n_oe_out,
   output logic [9:0] cell_q_out
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [31:0] ctrl_reg;
   logic [31:0] global_reg;
   logic [31:0] gpio_reg;
   logic [31:0] cell_cfg_reg;
   logic [31:0] cell_data_reg;
   logic [31:0] powerup_reg;
   logic pwr_load_pulse;
   logic [3:0] pins_sync;
   logic cwc_pin_sync;
   ccp_pkg::ccp_state_t state;
   ccp_pkg::ccp_state_t next_state;
   logic chip_clr;
   logic [3:0] global_line;
   logic [3:0] column_line;
   logic [3:0] column_prev;
   logic [1:0] clk_sel0;
   logic [1:0] clk_sel1;
   logic [1:0] clr_sel;
   logic cluster_clk0;
   logic cluster_clk1;
   logic evt0;
   logic evt1;
   logic aclr0;
   logic aclr1;
   logic [9:0] comb;
   logic [9:0] cell_d;
   logic [9:0] q;
   logic [31:0] next_prdata;
   logic next_slverr;
   logic wr_en;
   logic [31:0] status_word;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   ccp_sync2 #(
      .WIDTH(4)
   ) u_sync_gclk (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in(global_clock_pins_in),
      .sync_out(pins_sync)
   );

   ccp_sync2 #(
      .WIDTH(1)
   ) u_sync_cwc (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in(chip_wide_clear_pin_n_in),
      .sync_out(cwc_pin_sync)
   );

   // ****************************************************************
   // APB slave
   // ****************************************************************
   // Zero wait states: pready rises in the first access cycle.
   assign wr_en = psel_in && penable_in && pwrite_in && pready_out;

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         pready_out <= 1'b0;
         prdata_out <= ccp_pkg::RST_ZERO;
         pslverr_out <= 1'b0;
      end
      else
      begin
         pready_out <= psel_in && !penable_in;
         prdata_out <= next_prdata;
         pslverr_out <= next_slverr;
      end
   end

   always_comb
   begin
      status_word = ccp_pkg::RST_ZERO;
      status_word[ccp_pkg::STS_Q +: 10] = q;
      status_word[ccp_pkg::STS_PINS +: 4] = pins_sync;
      status_word[ccp_pkg::STS_CWC_PIN] = cwc_pin_sync;
      status_word[ccp_pkg::STS_HOLD] = (state == ccp_pkg::CCP_HOLD);
      status_word[ccp_pkg::STS_COLUMN +: 4] = column_line;
   end

   always_comb
   begin
      next_prdata = ccp_pkg::RST_ZERO;
      next_slverr = 1'b0;
      if (psel_in && !penable_in)
      begin
         case (paddr_in)
            ccp_pkg::ADDR_CTRL: next_prdata = ctrl_reg;
            ccp_pkg::ADDR_GLOBAL: next_prdata = global_reg;
            ccp_pkg::ADDR_GPIO: next_prdata = gpio_reg;
            ccp_pkg::ADDR_CELL_CFG: next_prdata = cell_cfg_reg;
            ccp_pkg::ADDR_CELL_DATA: next_prdata = cell_data_reg;
            ccp_pkg::ADDR_POWERUP: next_prdata = powerup_reg;
            ccp_pkg::ADDR_STATUS: next_prdata = status_word;
            default: next_slverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         ctrl_reg <= ccp_pkg::RST_CTRL;
         global_reg <= ccp_pkg::RST_GLOBAL;
         gpio_reg <= ccp_pkg::RST_ZERO;
         cell_cfg_reg <= ccp_pkg::RST_ZERO;
         cell_data_reg <= ccp_pkg::RST_ZERO;
         powerup_reg <= ccp_pkg::RST_ZERO;
      end
      else if (wr_en)
      begin
         case (paddr_in)
            ccp_pkg::ADDR_CTRL: ctrl_reg <= pwdata_in & ccp_pkg::MASK_CTRL;
            ccp_pkg::ADDR_GLOBAL: global_reg <= pwdata_in & ccp_pkg::MASK_GLOBAL;
            ccp_pkg::ADDR_GPIO: gpio_reg <= pwdata_in & ccp_pkg::MASK_GPIO;
            ccp_pkg::ADDR_CELL_CFG: cell_cfg_reg <= pwdata_in & ccp_pkg::MASK_CELL;
            ccp_pkg::ADDR_CELL_DATA: cell_data_reg <= pwdata_in & ccp_pkg::MASK_CELL;
            ccp_pkg::ADDR_POWERUP: powerup_reg <= pwdata_in & ccp_pkg::MASK_POWERUP;
            default:
            begin
            end
         endcase
      end
   end

   // The power-up load bit is a strobe; it is never stored.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         pwr_load_pulse <= 1'b0;
      end
      else
      begin
         pwr_load_pulse <= wr_en && (paddr_in == ccp_pkg::ADDR_CTRL)
            && pwdata_in[ccp_pkg::CTRL_PWR_LOAD];
      end
   end

   // ****************************************************************
   // Chip-wide clear and power-up hold
   // ****************************************************************
   always_comb
   begin
      next_state = state;
      case (state)
         ccp_pkg::CCP_HOLD:
         begin
            if (!CWC_ENABLE || cwc_pin_sync)
            begin
               next_state = ccp_pkg::CCP_USER;
            end
         end
         ccp_pkg::CCP_USER: next_state = ccp_pkg::CCP_USER;
         default: next_state = ccp_pkg::CCP_HOLD;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         state <= ccp_pkg::CCP_HOLD;
      end
      else
      begin
         state <= next_state;
      end
   end

   // The clear comes from its own pin, never from a global line.
   // pin clears all cell registers
   assign chip_clr = CWC_ENABLE && ((state == ccp_pkg::CCP_HOLD) || !cwc_pin_sync);

   // ****************************************************************
   // Pin drivers
   // ****************************************************************
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         global_clock_pins_out <= 4'h0;
         global_clock_pins_oe_out <= 4'h0;
         chip_wide_clear_pin_n_out <= 1'b0;
         chip_wide_clear_pin_n_oe_out <= 1'b0;
      end
      else
      begin
         global_clock_pins_out <= gpio_reg[ccp_pkg::GPIO_OUT +: 4];
         global_clock_pins_oe_out <= gpio_reg[ccp_pkg::GPIO_OE +: 4]
            & ~global_reg[ccp_pkg::GLB_PIN_CLK +: 4];
         chip_wide_clear_pin_n_out <= gpio_reg[ccp_pkg::GPIO_CWC_OUT];
         chip_wide_clear_pin_n_oe_out <= !CWC_ENABLE && gpio_reg[ccp_pkg::GPIO_CWC_OE];
      end
   end

   // ****************************************************************
   // Global network and column buffers
   // ****************************************************************
   always_comb
   begin
      for (int i = 0; i < ccp_pkg::NUM_GLOBAL; i++)
      begin
         if (global_reg[ccp_pkg::GLB_INT_SEL + i])
         begin
            global_line[i] = global_reg[ccp_pkg::GLB_INT_VAL + i];
         end
         else
         begin
            global_line[i] = global_reg[ccp_pkg::GLB_PIN_CLK + i] && pins_sync[i];
         end
      end
   end

   // Lines are registered once so edge detection sees clean levels.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         column_line <= 4'h0;
         column_prev <= 4'h0;
      end
      else
      begin
         column_line <= global_line & global_reg[ccp_pkg::GLB_COL_EN +: 4];
         column_prev <= column_line;
      end
   end

   // ****************************************************************
   // Cluster clock and control selection
   // ****************************************************************
   assign clk_sel0 = global_reg[ccp_pkg::GLB_CLK0_SEL +: 2];
   assign clk_sel1 = global_reg[ccp_pkg::GLB_CLK1_SEL +: 2];
   assign clr_sel = global_reg[ccp_pkg::GLB_CLR_SEL +: 2];
   assign cluster_clk0 = column_line[clk_sel0];
   assign cluster_clk1 = column_line[clk_sel1];
   assign evt0 = cluster_clk0 && !column_prev[clk_sel0];
   assign evt1 = cluster_clk1 && !column_prev[clk_sel1];
   assign aclr0 = column_line[clr_sel];
   assign aclr1 = ctrl_reg[ccp_pkg::CTRL_ACLR1];

   // ****************************************************************
   // Cascade chains and cells
   // ****************************************************************
   always_comb
   begin
      comb[0] = cell_data_reg[ccp_pkg::DAT_DATA];
      for (int i = 1; i < ccp_pkg::NUM_CELLS; i++)
      begin
         comb[i] = cell_data_reg[ccp_pkg::DAT_DATA + i]
            ^ (cell_data_reg[ccp_pkg::DAT_CASCADE + i] && comb[i-1]);
      end
   end

   always_comb
   begin
      cell_d[0] = comb[0];
      for (int i = 1; i < ccp_pkg::NUM_CELLS; i++)
      begin
         cell_d[i] = cell_cfg_reg[ccp_pkg::CFG_CHAIN_SEL + i] ? q[i-1] : comb[i];
      end
   end

   genvar g;
   generate
      for (g = 0; g < ccp_pkg::NUM_CELLS; g++)
      begin : gen_cell
         ccp_pkg::ccp_cell_ctrl_t cell_ctrl;

         always_comb
         begin
            cell_ctrl.chip_clr = chip_clr;
            cell_ctrl.aclr = cell_cfg_reg[ccp_pkg::CFG_CLR_PICK + g] ? aclr1 : aclr0;
            cell_ctrl.aload = ctrl_reg[ccp_pkg::CTRL_ALOAD];
            cell_ctrl.aload_one = ctrl_reg[ccp_pkg::CTRL_ALOAD_ONE];
            cell_ctrl.pwr_load = pwr_load_pulse;
            cell_ctrl.pwr_val = powerup_reg[g];
            cell_ctrl.clk_evt = cell_cfg_reg[ccp_pkg::CFG_CLK_PICK + g] ? evt1 : evt0;
            cell_ctrl.ena = ctrl_reg[ccp_pkg::CTRL_ENA];
            cell_ctrl.sclr = ctrl_reg[ccp_pkg::CTRL_SCLR];
            cell_ctrl.sload = ctrl_reg[ccp_pkg::CTRL_SLOAD];
         end

         ccp_cell u_cell (
            .clk_in(clk_in),
            .sys_rst_in(sys_rst_in),
            .ctrl_in(cell_ctrl),
            .d_in(cell_d[g]),
            .load_data_in(cell_data_reg[ccp_pkg::DAT_FOURTH + g]),
            .q_out(q[g])
         );
      end
   endgenerate

   assign cell_q_out = q;

endmodule

/* verif/ccp_cluster_ctrl_checker.sv */
// Port-level assertions for the cluster register controller.
`timescale 1ns/1ps
module ccp_cluster_ctrl_checker #(
   parameter logic CWC_ENABLE = 1'h1
)
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic chip_wide_clear_pin_n_in,
   input wire logic chip_wide_clear_pin_n_oe_out,
   input wire logic [9:0] cell_q_out
);
   logic [1:0] high_cnt;
   logic released;
   logic mapped;
   assign mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= 8'h18);
   // The pin crosses two synchroniser stages, so the hold may end only after three high edges.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         high_cnt <= 2'h0;
         released <= 1'h0;
      end
      else
      begin
         high_cnt <= chip_wide_clear_pin_n_in ? high_cnt + 2'h1 : 2'h0;
         released <= released || (high_cnt == 2'h3);
      end
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   sequence s_setup;
      psel_in && !penable_in;
   endsequence
   sequence s_clear_low;
      (CWC_ENABLE && !chip_wide_clear_pin_n_in)[*4];
   endsequence
   property p_setup_ready;
      s_setup |=> pready_out;
   endproperty
   a_setup_ready: assert property (p_setup_ready)
      else $error("ready missing after setup");
   property p_ready_single;
      pready_out |=> !pready_out;
   endproperty
   a_ready_single: assert property (p_ready_single)
      else $error("ready longer than one cycle");
   property p_ready_cause;
      pready_out |-> $past(psel_in && !penable_in);
   endproperty
   a_ready_cause: assert property (p_ready_cause)
      else $error("ready without setup");
   property p_err_map;
      pready_out |-> (pslverr_out == !mapped);
   endproperty
   a_err_map: assert property (p_err_map)
      else $error("error flag does not match address");
   property p_err_data;
      pslverr_out |-> (prdata_out == 32'h0);
   endproperty
   a_err_data: assert property (p_err_data)
      else $error("read data not zero on error");
   property p_chip_clear;
      s_clear_low |-> (cell_q_out == 10'h0);
   endproperty
   a_chip_clear: assert property (p_chip_clear)
      else $error("cells not cleared by chip clear");
   property p_hold;
      (CWC_ENABLE && !released) |-> (cell_q_out == 10'h0);
   endproperty
   a_hold: assert property (p_hold)
      else $error("cells left hold early");
   property p_cwc_io;
      CWC_ENABLE |-> !chip_wide_clear_pin_n_oe_out;
   endproperty
   a_cwc_io: assert property (p_cwc_io)
      else $error("clear pin driven while used as clear");
endmodule

bind ccp_cluster_ctrl ccp_cluster_ctrl_checker #(.CWC_ENABLE(CWC_ENABLE)) u_checker (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .paddr_in(paddr_in), .psel_in(psel_in),
   .penable_in(penable_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .chip_wide_clear_pin_n_in(chip_wide_clear_pin_n_in),
   .chip_wide_clear_pin_n_oe_out(chip_wide_clear_pin_n_oe_out), .cell_q_out(cell_q_out));

/* verif/ccp_fabric_model.sv */
// Fabric-side model driving the clock pins and the chip-wide clear pin.
`timescale 1ns/1ps
module ccp_fabric_model #(
   parameter int HIGH_CYC = 3
)
(
   input wire logic clk_in,
   input wire logic hold_clear_in,
   input wire logic [3:0] pulse_in,
   input wire logic [3:0] dut_pins_in,
   input wire logic [3:0] dut_pins_oe_in,
   input wire logic dut_clear_in,
   input wire logic dut_clear_oe_in,
   output logic [3:0] pins_wire_out,
   output logic clear_wire_n_out
);
   logic [3:0] drive = 4'h0;
   int cnt = 0;
   // Pins only pulse on request, so a line stands still between clock events.
   always_ff @(posedge clk_in)
   begin
      if (pulse_in != 4'h0)
      begin
         drive <= pulse_in;
         cnt <= HIGH_CYC;
      end
      else if (cnt > 0)
         cnt <= cnt - 1;
      else
         drive <= 4'h0;
   end
   assign pins_wire_out = (dut_pins_oe_in & dut_pins_in) | (~dut_pins_oe_in & drive);
   assign clear_wire_n_out = dut_clear_oe_in ? dut_clear_in : !hold_clear_in;
endmodule

/* verif/ccp_cluster_ctrl_tb.sv */
// Self-checking bench for the cluster register controller.
`timescale 1ns/1ps
module ccp_cluster_ctrl_tb;
   localparam logic [7:0] RA [9] = '{8'h0, 8'h4, 8'h8, 8'hc, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h40};
   localparam logic [31:0] RV [9] = '{32'h4, 32'hf000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h8000,
      32'h0, 32'h0};
   localparam logic [31:0] RM [9] = '{32'h3f, 32'h3f_ffff, 32'h3ff, 32'h3fff_ffff,
      32'h3fff_ffff, 32'h3ff, 32'h8000, 32'h0, 32'h0};
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] paddr = 8'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdata, glob;
   logic pready, pslverr, rerr, clr_out, clr_oe, clr_oe2, clr_wire_n, colen, use_pin;
   logic hold_clear = 1'h1;
   logic [3:0] pins_out, pins_oe, pins_wire;
   logic [3:0] pulse = 4'h0;
   logic [9:0] q, q2, d, f, casc, chain, pick, qexp;
   logic [2:0] c;
   logic [31:0] rng = 32'h1;
   int errors = 0;
   int checks = 0;

   ccp_cluster_ctrl u_dut (.clk_in(clk), .sys_rst_in(rst), .paddr_in(paddr), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .global_clock_pins_in(pins_wire),
      .global_clock_pins_out(pins_out), .global_clock_pins_oe_out(pins_oe),
      .chip_wide_clear_pin_n_in(clr_wire_n), .chip_wide_clear_pin_n_out(clr_out),
      .chip_wide_clear_pin_n_oe_out(clr_oe), .cell_q_out(q));
   // Second copy with the clear function compiled out, fed from the same bus and pins.
   ccp_cluster_ctrl #(.CWC_ENABLE(1'h0)) u_dut_io (.clk_in(clk), .sys_rst_in(rst),
      .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .pwdata_in(pwdata), .prdata_out(), .pready_out(), .pslverr_out(),
      .global_clock_pins_in(pins_wire), .global_clock_pins_out(),
      .global_clock_pins_oe_out(), .chip_wide_clear_pin_n_in(clr_wire_n),
      .chip_wide_clear_pin_n_out(), .chip_wide_clear_pin_n_oe_out(clr_oe2), .cell_q_out(q2));
   ccp_fabric_model #(.HIGH_CYC(3)) u_fabric (.clk_in(clk), .hold_clear_in(hold_clear),
      .pulse_in(pulse), .dut_pins_in(pins_out), .dut_pins_oe_in(pins_oe),
      .dut_clear_in(clr_out), .dut_clear_oe_in(clr_oe), .pins_wire_out(pins_wire),
      .clear_wire_n_out(clr_wire_n));

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   function automatic logic [9:0] next_q(input logic [9:0] qo, dd, ff, cs, ch, pk,
      input logic [2:0] cc, input logic en);
      logic [9:0] comb;
      logic [9:0] nq;
      comb[0] = dd[0];
      for (int i = 1; i < 10; i++)
         comb[i] = dd[i] ^ (cs[i] & comb[i - 1]);
      nq = comb;
      for (int i = 1; i < 10; i++)
         if (ch[i])
            nq[i] = qo[i - 1];
      if (cc[0])
         nq = 10'h0;
      else if (cc[1])
         nq = ff;
      if (!cc[2] || !en)
         nq = qo;
      return (nq & ~pk) | (qo & pk);
   endfunction

   task automatic finish_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_q(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Any wait for ready is bounded; a silent slave ends the run.
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'h1 && n < 16);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1)
      begin
         errors++;
         finish_test();
      end
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      finish_test();
   end

   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      chk_q(q, 10'h0);
      chk_q(q2, 10'h0);
      for (int i = 0; i < 9; i++)
      begin
         apb(1'h0, RA[i], 32'h0);
         chk_word(rdata, RV[i]);
         chk_word({31'h0, rerr}, (i > 6) ? 32'h1 : 32'h0);
         apb(1'h1, RA[i], 32'hffff_ffff);
         apb(1'h0, RA[i], 32'h0);
         chk_word(rdata, RM[i]);
         apb(1'h1, RA[i], RV[i]);
      end
      apb(1'h1, 8'h0, 32'h34);
      repeat (3) @(posedge clk);
      chk_q(q, 10'h0);
      chk_q(q2, 10'h3ff);
      hold_clear <= 1'h0;
      repeat (8) @(posedge clk);
      chk_q(q, 10'h3ff);
      pick = 10'(rnd());
      apb(1'h1, 8'hc, {12'h0, pick, 10'h0});
      apb(1'h1, 8'h0, 32'h3c);
      repeat (3) @(posedge clk);
      chk_q(q, ~pick);
      for (int i = 0; i < 3; i++)
      begin
         f = 10'(rnd());
         apb(1'h1, 8'h10, {12'h0, f, 10'h0});
         apb(1'h1, 8'h0, 32'h14);
         repeat (3) @(posedge clk);
         chk_q(q, f);
      end
      qexp = 10'(rnd());
      apb(1'h1, 8'h14, {22'h0, qexp});
      apb(1'h1, 8'h0, 32'h40);
      repeat (3) @(posedge clk);
      chk_q(q, qexp);
      for (int i = 0; i < 16; i++)
      begin
         d = 10'(rnd());
         f = 10'(rnd());
         casc = 10'(rnd()) & 10'h3fe;
         chain = 10'(rnd()) & 10'h3fe;
         pick = 10'(rnd());
         c = (i < 2) ? 3'h4 : 3'(rnd());
         colen = (i < 2) || rng[8];
         use_pin = rng[9];
         glob = 32'h34_e000 | {19'h0, colen, 12'h0} | (use_pin ? 32'h1 : 32'h100);
         apb(1'h1, 8'hc, {2'h0, chain, 10'h0, pick});
         apb(1'h1, 8'h10, {2'h0, casc, f, d});
         apb(1'h1, 8'h0, {29'h0, c});
         apb(1'h1, 8'h4, glob);
         if (use_pin)
         begin
            pulse <= 4'h1;
            @(posedge clk);
            pulse <= 4'h0;
         end
         else
            apb(1'h1, 8'h4, glob | 32'h10);
         repeat (8) @(posedge clk);
         apb(1'h1, 8'h4, glob);
         qexp = next_q(qexp, d, f, casc, chain, pick, c, colen);
         chk_q(q, qexp);
      end
      pick = 10'(rnd());
      apb(1'h1, 8'h8, {22'h0, pick});
      // The pin drivers are registered behind the register, so the new value shows one edge on; the check waits two.
      repeat (2) @(posedge clk);
      chk_word({24'h0, pins_oe, pins_out}, {24'h0, pick[7:4] & ~glob[3:0], pick[3:0]});
      chk_word({29'h0, clr_out, clr_oe, clr_oe2}, {29'h0, pick[8], 1'h0, pick[9]});
      apb(1'h1, 8'h8, 32'h0);
      apb(1'h1, 8'h0, 32'h34);
      hold_clear <= 1'h1;
      repeat (5) @(posedge clk);
      chk_q(q, 10'h0);
      chk_q(q2, 10'h3ff);
      hold_clear <= 1'h0;
      repeat (5) @(posedge clk);
      chk_q(q, 10'h3ff);
      // Column line 3 driven internally is the selected cluster clear; it beats the preset.
      apb(1'h1, 8'h4, 32'h34_e880);
      repeat (3) @(posedge clk);
      chk_q(q, 10'h0);
      chk_q(q2, 10'h0);
      finish_test();
   end
endmodule
